// >>> rtl/adc_clock_and_mode_control.sv
// Converter clock selection, diagnostic and calibration mode control
// How it works
// - Sync clear: local clock and sync used
// - Driver bit set: local clock onto backplane
// - Driver bit clear: backplane clock undriven
// - Select bit picks oscillator or external clock
// - Shared sync overrides converter clock select
// - Processing clock: converter or oscillator
// - Processing clock level is only output; all logic runs on sys_clk
// - Force bit drives first pass negative
// - Track-only bit holds track mode
// - Control register: diag 4-0, mode 7-5
// - Selection 0 gives combined result
// - Selections 1-29 give error accumulators
// - Selections 30/31 give single passes
// - Mode values 0-7 select calibration
// - Latched count readable after trigger
// - Timing setup fields at index 24
// - Shared sync uses backplane clock, sync
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module adc_clock_and_mode_control (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Clock and sync sources
    input  wire logic        osc_clk_in,
    input  wire logic        ext_clk_in,
    input  wire logic        bp_clk_i,
    output logic             bp_clk_o,
    output logic             bp_clk_oe,
    input  wire logic        bp_sync_i,
    input  wire logic        local_sync,
    // Selected clock levels and controls
    output logic             conv_clk_lvl,
    output logic             proc_clk_lvl,
    output logic             sync_sel,
    output logic             use_backplane,
    output logic             proc_from_osc,
    output logic             track_only,
    output logic             force_full_scale,
    output logic      [4:0]  converter_diag_select,
    output logic      [2:0]  converter_cal_mode,
    // Converter data path
    input  wire logic [22:0] first_pass,
    input  wire logic [22:0] second_pass,
    input  wire logic [22:0] combined,
    input  wire logic [22:0] err_acc_data,
    output logic      [22:0] conv_data,
    // Trigger capture
    input  wire logic        trig_pulse,
    input  wire logic [24:0] decim_count,
    input  wire logic        alt_decim_count,
    input  wire logic [1:0]  pack_shift
);
    logic [15:0] timing_q;
    logic [4:0]  diag_q;
    logic [2:0]  mode_q;
    logic [24:0] decim_count_latch_q;
    logic        alt_decim_count_latch_q;
    logic [1:0]  shift_latch_q;
    logic [3:0]  src_s;
    logic        osc_s;
    logic        ext_s;
    logic        bp_clk_s;
    logic        bp_sync_s;
    logic        local_clk;
    logic        conv_clk_d;
    logic        access;
    logic        wr_take;
    logic        capture;
    logic [7:0]  idx;
    logic        mapped;
    logic [31:0] rdata_d;

    level_sync #(.W(4)) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({bp_sync_i, bp_clk_i, ext_clk_in, osc_clk_in}),
        .sync_out (src_s)
    );
    assign {bp_sync_s, bp_clk_s, ext_s, osc_s} = src_s;

    // APB decode; answer one cycle into the access phase
    assign access  = psel && penable && !pready;
    assign wr_take = psel && penable && pready && pwrite;
    assign idx     = paddr[9:2];

    always_comb begin
        mapped  = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'b00);
        rdata_d = 32'h00000000;
        if (paddr == clk_mode_pkg::byte_addr(clk_mode_pkg::IDX_LATCH_0)) begin
            rdata_d = {21'h000000, alt_decim_count_latch_q,
                       shift_latch_q, decim_count_latch_q[7:0]};
        end else if (paddr ==
                     clk_mode_pkg::byte_addr(clk_mode_pkg::IDX_LATCH_1)) begin
            rdata_d = {24'h000000, decim_count_latch_q[15:8]};
        end else if (paddr ==
                     clk_mode_pkg::byte_addr(clk_mode_pkg::IDX_LATCH_2)) begin
            rdata_d = {24'h000000, decim_count_latch_q[23:16]};
        end else if (paddr ==
                     clk_mode_pkg::byte_addr(clk_mode_pkg::IDX_LATCH_3)) begin
            rdata_d = {31'h00000000, decim_count_latch_q[24]};
        end else if (idx != clk_mode_pkg::IDX_TIMING_SETUP &&
                     idx != clk_mode_pkg::IDX_CONV_CTRL) begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= access;
            prdata  <= (access && !pwrite) ? rdata_d : 32'h00000000;
            pslverr <= access && !mapped;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timing_q <= clk_mode_pkg::TIMING_RESET;
        end else if (wr_take && paddr ==
                     clk_mode_pkg::byte_addr(clk_mode_pkg::IDX_TIMING_SETUP)) begin
            timing_q <= pwdata[15:0] & clk_mode_pkg::TIMING_MASK;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            diag_q <= clk_mode_pkg::DIAG_RESET;
            mode_q <= clk_mode_pkg::MODE_RESET;
        end else if (wr_take && paddr ==
                     clk_mode_pkg::byte_addr(clk_mode_pkg::IDX_CONV_CTRL)) begin
            diag_q <= pwdata[clk_mode_pkg::DIAG_LSB +: 5];
            mode_q <= pwdata[clk_mode_pkg::MODE_LSB +: 3];
        end
    end

    // count latched on trigger or capture write
    assign capture = trig_pulse || (wr_take && paddr ==
                     clk_mode_pkg::byte_addr(clk_mode_pkg::IDX_LATCH_2));
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            decim_count_latch_q     <= '0;
            alt_decim_count_latch_q <= 1'b0;
            shift_latch_q           <= 2'b00;
        end else if (capture) begin
            decim_count_latch_q     <= decim_count;
            alt_decim_count_latch_q <= alt_decim_count;
            shift_latch_q           <= pack_shift;
        end
    end

    assign local_clk = timing_q[clk_mode_pkg::BIT_CONV_EXT] ? ext_s : osc_s;
    assign conv_clk_d = timing_q[clk_mode_pkg::BIT_SHARED_SYNC] ?
                        bp_clk_s : local_clk;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conv_clk_lvl  <= 1'b0;
            sync_sel      <= 1'b0;
            use_backplane <= 1'b0;
        end else begin
            conv_clk_lvl  <= conv_clk_d;
            sync_sel      <= timing_q[clk_mode_pkg::BIT_SHARED_SYNC] ?
                             bp_sync_s : local_sync;
            use_backplane <= timing_q[clk_mode_pkg::BIT_SHARED_SYNC];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            proc_clk_lvl  <= 1'b0;
            proc_from_osc <= 1'b0;
        end else begin
            proc_clk_lvl  <= timing_q[clk_mode_pkg::BIT_PROC_OSC] ?
                             osc_s : conv_clk_d;
            proc_from_osc <= timing_q[clk_mode_pkg::BIT_PROC_OSC];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bp_clk_o  <= 1'b0;
            bp_clk_oe <= 1'b0;
        end else begin
            bp_clk_o  <= local_clk;
            bp_clk_oe <= timing_q[clk_mode_pkg::BIT_BP_DRIVER];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            track_only            <= 1'b0;
            force_full_scale      <= 1'b0;
            converter_diag_select <= clk_mode_pkg::DIAG_RESET;
            converter_cal_mode    <= clk_mode_pkg::MODE_RESET;
        end else begin
            track_only            <= timing_q[clk_mode_pkg::BIT_TRACK_ONLY];
            force_full_scale      <= timing_q[clk_mode_pkg::BIT_FORCE_FS];
            converter_diag_select <= diag_q;
            converter_cal_mode    <= mode_q;
        end
    end

    conv_diag_mux u_mux (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .diag_sel     (diag_q),
        .force_fs     (timing_q[clk_mode_pkg::BIT_FORCE_FS]),
        .first_pass   (first_pass),
        .second_pass  (second_pass),
        .combined     (combined),
        .err_acc_data (err_acc_data),
        .conv_data_q  (conv_data)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_drive_on;
        wr_take && paddr == 32'h00000090 && pwdata[1] |-> ##2 bp_clk_oe;
    endproperty
    a_drive_on: assert property (p_drive_on) else $error("driver not on");
    property p_drive_off;
        !timing_q[1] |=> !bp_clk_oe;
    endproperty
    a_drive_off: assert property (p_drive_off) else $error("driving");
    property p_local;
        !timing_q[0] && !timing_q[2] |=> conv_clk_lvl == $past(osc_s);
    endproperty
    a_local: assert property (p_local) else $error("not oscillator");
    property p_shared;
        timing_q[0] |=> conv_clk_lvl == $past(bp_clk_s)
                        && sync_sel == $past(bp_sync_s);
    endproperty
    a_shared: assert property (p_shared) else $error("not backplane");
    property p_own_sync;
        !timing_q[0] |=> sync_sel == $past(local_sync);
    endproperty
    a_own_sync: assert property (p_own_sync) else $error("sync wrong");
    property p_proc;
        timing_q[3] |=> proc_clk_lvl == $past(osc_s);
    endproperty
    a_proc: assert property (p_proc) else $error("proc clock wrong");
    property p_track;
        wr_take && paddr == 32'h00000090
            |-> ##2 track_only == $past(pwdata[7], 2);
    endproperty
    a_track: assert property (p_track) else $error("track bit lost");
    property p_ctrl;
        wr_take && paddr == 32'h00000098 |-> ##2
            converter_diag_select == $past(pwdata[4:0], 2)
            && converter_cal_mode == $past(pwdata[7:5], 2);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control fields wrong");
    property p_unused;
        wr_take && paddr == 32'h00000090 |=> timing_q[5:4] == 2'b00
            && timing_q[15:8] == 8'h00;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bit kept");
    property p_latch;
        trig_pulse |=> decim_count_latch_q == $past(decim_count);
    endproperty
    a_latch: assert property (p_latch) else $error("count not latched");
    c_master: cover property (bp_clk_oe && use_backplane);
    c_normal: cover property (converter_cal_mode == clk_mode_pkg::CAL_NORMAL);
    c_ext: cover property (timing_q[2] && !timing_q[0] ##1 conv_clk_lvl);
endmodule : adc_clock_and_mode_control
`default_nettype wire

// >>> rtl/clk_mode_pkg.sv
// Package: register map, field positions, reset values and constants
`default_nettype none
package clk_mode_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMING_SETUP = 8'h24;
    localparam logic [7:0] IDX_CONV_CTRL    = 8'h26;
    localparam logic [7:0] IDX_LATCH_0      = 8'h28;
    localparam logic [7:0] IDX_LATCH_1      = 8'h2a;
    localparam logic [7:0] IDX_LATCH_2      = 8'h2c;
    localparam logic [7:0] IDX_LATCH_3      = 8'h2e;

    // Timing setup fields
    localparam int BIT_SHARED_SYNC  = 0;
    localparam int BIT_BP_DRIVER    = 1;
    localparam int BIT_CONV_EXT     = 2;
    localparam int BIT_PROC_OSC     = 3;
    localparam int BIT_FORCE_FS     = 6;
    localparam int BIT_TRACK_ONLY   = 7;
    localparam logic [15:0] TIMING_MASK  = 16'h00cf;
    localparam logic [15:0] TIMING_RESET = 16'h0000;

    // Converter control fields
    localparam int DIAG_LSB = 0;
    localparam int MODE_LSB = 5;
    localparam logic [4:0] DIAG_RESET = 5'h00;
    localparam logic [2:0] MODE_RESET = 3'h0;

    // Diagnostic selections
    localparam logic [4:0] DIAG_NORMAL    = 5'h00;
    localparam logic [4:0] DIAG_THIRD_HI  = 5'h09;
    localparam logic [4:0] DIAG_SECOND_HI = 5'h13;
    localparam logic [4:0] DIAG_FIRST_HI  = 5'h1c;
    localparam logic [4:0] DIAG_GAIN      = 5'h1d;
    localparam logic [4:0] DIAG_FIRST     = 5'h1e;
    localparam logic [4:0] DIAG_SECOND    = 5'h1f;

    // Converter word width and negative full scale
    localparam int CONV_W = 23;
    localparam logic [22:0] NEG_FULL_SCALE = 23'h400000;

    // Latched decimation count
    localparam int CNT_W = 25;

    typedef enum logic [2:0] {
        CAL_RESET      = 3'h0,
        CAL_UNCAL      = 3'h1,
        CAL_DITHER     = 3'h2,
        CAL_GAIN       = 3'h3,
        CAL_DAC        = 3'h4,
        CAL_NO_UPDATE  = 3'h5,
        CAL_NO_GAIN_UP = 3'h6,
        CAL_NORMAL     = 3'h7
    } cal_mode_e;

    function automatic logic [31:0] byte_addr(input logic [7:0] idx);
        byte_addr = {22'h000000, idx, 2'b00};
    endfunction : byte_addr

endpackage : clk_mode_pkg
`default_nettype wire

// >>> rtl/level_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : level_sync
`default_nettype wire

// >>> rtl/conv_diag_mux.sv
// Selects the converter word delivered to the processing path
`timescale 1ns/1ps
`default_nettype none
module conv_diag_mux (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  diag_sel,
    input  wire logic        force_fs,
    input  wire logic [22:0] first_pass,
    input  wire logic [22:0] second_pass,
    input  wire logic [22:0] combined,
    input  wire logic [22:0] err_acc_data,
    output logic      [22:0] conv_data_q
);
    logic [22:0] first_eff;
    logic [22:0] conv_data_d;

    assign first_eff = force_fs ? clk_mode_pkg::NEG_FULL_SCALE : first_pass;

    always_comb begin
        if (diag_sel == clk_mode_pkg::DIAG_NORMAL) begin
            conv_data_d = combined;
        end else if (diag_sel == clk_mode_pkg::DIAG_FIRST) begin
            conv_data_d = first_eff;
        end else if (diag_sel == clk_mode_pkg::DIAG_SECOND) begin
            conv_data_d = second_pass;
        end else begin
            conv_data_d = err_acc_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conv_data_q <= '0;
        end else begin
            conv_data_q <= conv_data_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_force_fs;
        (diag_sel == 5'h1e) && force_fs |=> conv_data_q == 23'h400000;
    endproperty
    a_force_fs: assert property (p_force_fs) else $error("forced scale lost");
    property p_second;
        diag_sel == 5'h1f |=> conv_data_q == $past(second_pass);
    endproperty
    a_second: assert property (p_second) else $error("second pass wrong");
    property p_normal;
        diag_sel == 5'h00 |=> conv_data_q == $past(combined);
    endproperty
    a_normal: assert property (p_normal) else $error("normal output wrong");
    property p_acc;
        (diag_sel != 5'h00) && (diag_sel < 5'h1e)
            |=> conv_data_q == $past(err_acc_data);
    endproperty
    a_acc: assert property (p_acc) else $error("accumulator not shown");
    c_force: cover property ((diag_sel == 5'h1e) && force_fs);
endmodule : conv_diag_mux
`default_nettype wire

// >>> testbench/backplane_peer.sv
// Peer module on the shared backplane clock line, with its pull-up
`timescale 1ns/1ps
`default_nettype none
module backplane_peer (
    input  wire logic dut_clk,
    input  wire logic dut_oe,
    input  wire logic peer_drive,
    input  wire logic peer_clk,
    output logic      bp_line
);
    always_comb begin
        if (dut_oe && peer_drive)
            bp_line = 1'bx;
        else if (dut_oe)
            bp_line = dut_clk;
        else if (peer_drive)
            bp_line = peer_clk;
        else
            bp_line = 1'b1;
    end
endmodule : backplane_peer
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the clock and converter mode control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] TS_A = 32'h0000_0090;
    localparam logic [31:0] CC_A = 32'h0000_0098;
    localparam logic [24:0] CNT  = 25'h1a5c3e7;
    logic        sys_clk, rst = 1'b1, pready, pslverr, er, bp_clk_i;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic        osc_clk_in = 1'b0, ext_clk_in = 1'b0, bp_clk_o, bp_clk_oe;
    logic        bp_sync_i = 1'b0, local_sync = 1'b0, conv_clk_lvl;
    logic        proc_clk_lvl, sync_sel, use_backplane, proc_from_osc;
    logic        track_only, force_full_scale, trig_pulse = 1'b0;
    logic        alt_decim_count = 1'b0, peer_drive = 1'b0, peer_clk = 1'b0;
    logic [4:0]  converter_diag_select;
    logic [2:0]  converter_cal_mode, m;
    logic [1:0]  pack_shift = 2'h0;
    logic [22:0] first_pass = 23'h111111, second_pass = 23'h222222;
    logic [22:0] combined = 23'h333333, err_acc_data = 23'h444444;
    logic [22:0] conv_data, e;
    logic [24:0] decim_count = 25'h0;
    logic [18:0] r;
    int          fails = 0, n_compared = 0;
    // slow-clock rows 6, 7 use oscillator
    // Timing byte, osc ext pdrv pclk bps lcs, conv proc sync oe local
    logic [18:0] rows [9] = '{
        {8'h00, 6'b101001, 5'b11101}, {8'h04, 6'b101110, 5'b00000},
        {8'h05, 6'b111010, 5'b00101}, {8'h01, 6'b000001, 5'b11000},
        {8'h03, 6'b010110, 5'b00110}, {8'h07, 6'b010001, 5'b11011},
        {8'h0c, 6'b101100, 5'b01000}, {8'h0d, 6'b011110, 5'b10101},
        {8'hf0, 6'b100010, 5'b11001}};

    adc_clock_and_mode_control u_dut (
        .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .osc_clk_in, .ext_clk_in,
        .bp_clk_i, .bp_clk_o, .bp_clk_oe, .bp_sync_i, .local_sync,
        .conv_clk_lvl, .proc_clk_lvl, .sync_sel, .use_backplane,
        .proc_from_osc, .track_only, .force_full_scale,
        .converter_diag_select, .converter_cal_mode, .first_pass,
        .second_pass, .combined, .err_acc_data, .conv_data,
        .trig_pulse, .decim_count, .alt_decim_count, .pack_shift
    );

    backplane_peer u_peer (
        .dut_clk(bp_clk_o), .dut_oe(bp_clk_oe), .peer_drive(peer_drive),
        .peer_clk(peer_clk), .bp_line(bp_clk_i)
    );

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] g);
        n_compared++;
        if (g !== ex) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, {31'h0, pready});
        if (pready !== 1'b1) begin
            final_report();
        end else begin
            rd = prdata;
            er = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic rdchk(input logic [31:0] a, input logic [31:0] ex,
                         input logic x);
        apb(1'b0, a, 32'h0);
        chk("pslverr", {31'h0, x}, {31'h0, er});
        if (!x)
            chk("prdata", ex, rd);
    endtask : rdchk

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        chk("reset", {23'h0, clk_mode_pkg::DIAG_RESET,
            clk_mode_pkg::MODE_RESET, 1'b0},
            {conv_data, converter_diag_select, converter_cal_mode,
            bp_clk_oe});
        rst <= 1'b0;
        // Clock routing rows; rows 6 and 7 keep processing on oscillator
        foreach (rows[i]) begin
            r = rows[i];
            apb(1'b1, TS_A, {16'h0000, 8'hff, r[18:11]});
            osc_clk_in <= r[10];
            ext_clk_in <= r[9];
            peer_drive <= r[8];
            peer_clk   <= r[7];
            bp_sync_i  <= r[6];
            local_sync <= r[5];
            repeat (8) @(posedge sys_clk);
            chk("clocks", {27'h0, r[4:0]}, {27'h0, conv_clk_lvl, proc_clk_lvl,
                sync_sel, bp_clk_oe, bp_clk_o});
            chk("status", {28'h0, r[18], r[17], r[14], r[11]},
                {28'h0, track_only, force_full_scale, proc_from_osc,
                use_backplane});
        end
        apb(1'b1, TS_A, 32'h0);
        for (int i = 0; i < 32; i++) begin
            m = (i < 8) ? i[2:0] : 3'h7;
            apb(1'b1, CC_A, {16'h0000, 8'hff, m, i[4:0]});
            repeat (4) @(posedge sys_clk);
            chk("ctrl", {24'h0, m, i[4:0]},
                {24'h0, converter_cal_mode, converter_diag_select});
            e = (i == 0) ? combined : (i < 30) ? err_acc_data :
                (i == 30) ? first_pass : second_pass;
            chk("conv_data", {9'h0, e}, {9'h0, conv_data});
        end
        apb(1'b1, TS_A, 32'h0000_0040);
        apb(1'b1, CC_A, 32'h0000_00fe);
        repeat (4) @(posedge sys_clk);
        chk("force", {9'h0, clk_mode_pkg::NEG_FULL_SCALE},
            {9'h0, conv_data});
        rdchk(TS_A, 32'h0, 1'b0);
        rdchk(CC_A, 32'h0, 1'b0);
        rdchk(32'h0000_0094, 32'h0, 1'b1);
        rdchk(32'h0000_0091, 32'h0, 1'b1);
        apb(1'b1, 32'h0000_0094, 32'h0000_0003);
        repeat (4) @(posedge sys_clk);
        chk("stray", 32'h2, {30'h0, er, bp_clk_oe});
        decim_count     <= CNT;
        alt_decim_count <= 1'b1;
        pack_shift      <= 2'b10;
        trig_pulse      <= 1'b1;
        @(posedge sys_clk);
        trig_pulse      <= 1'b0;
        decim_count     <= ~CNT;
        alt_decim_count <= 1'b0;
        pack_shift      <= 2'b01;
        rdchk(32'h0000_00a0, {21'h0, 1'b1, 2'b10, CNT[7:0]}, 1'b0);
        rdchk(32'h0000_00a8, {24'h0, CNT[15:8]}, 1'b0);
        rdchk(32'h0000_00b0, {24'h0, CNT[23:16]}, 1'b0);
        rdchk(32'h0000_00b8, {31'h0, CNT[24]}, 1'b0);
        // Capture write copies the live count into the latch
        apb(1'b1, 32'h0000_00b0, 32'h0);
        rdchk(32'h0000_00a0, {21'h0, 1'b0, 2'b01, ~CNT[7:0]}, 1'b0);
        rdchk(32'h0000_00b8, {31'h0, ~CNT[24]}, 1'b0);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("reset2", 32'h0, {conv_data, converter_diag_select,
            converter_cal_mode, bp_clk_oe});
        rst <= 1'b0;
        // Block must accept writes again after a mid-run reset
        apb(1'b1, TS_A, 32'h0000_0002);
        repeat (4) @(posedge sys_clk);
        chk("driver", 32'h1, {31'h0, bp_clk_oe});
        final_report();
    end
endmodule : tb
`default_nettype wire
